/* File: dbg_bp_match.sv */
// one breakpoint comparator: access type and range overlap
`timescale 1ns/1ps
`default_nettype none
module dbg_bp_match
   import dbg_pkg::*;
(
   input wire logic [63:0] i_base,
   input wire logic [1:0] i_rw,
   input wire logic [1:0] i_len,
   input wire logic i_de,
   input wire logic i_insn_valid,
   input wire logic [63:0] i_insn_ip,
   input wire logic i_mem_valid,
   input wire logic i_mem_write,
   input wire logic i_mem_io,
   input wire logic [63:0] i_mem_addr,
   input wire logic [3:0] i_mem_size,
   output logic o_hit
);
   logic [63:0] mask;
   logic [63:0] lo;
   logic [63:0] hi;
   logic [63:0] acc_hi;
   logic type_ok;
   logic overlap;

   // range mask from length code; low bits drop out of the compare
   always_comb begin
      unique case (dbg_len_t'(i_len))
         DBG_LEN_1: mask = 64'hffff_ffff_ffff_ffff;
         DBG_LEN_2: mask = 64'hffff_ffff_ffff_fffe;
         DBG_LEN_4: mask = 64'hffff_ffff_ffff_fffc;
         DBG_LEN_8: mask = 64'hffff_ffff_ffff_fff8;
      endcase
   end

   // base is the masked address; misaligned bases are software's fault
   assign lo = i_base & mask;
   assign hi = lo | ~mask;
   assign acc_hi = i_mem_addr + {60'h0, i_mem_size} - 64'h1;
   // partial overlap counts: any accessed byte inside the range
   assign overlap = (i_mem_addr <= hi) && (acc_hi >= lo);

   // access-type qualification; io code is undefined without extensions
   always_comb begin
      unique case (dbg_access_t'(i_rw))
         DBG_AT_EXEC: type_ok = 1'b0;
         DBG_AT_WRITE: type_ok = i_mem_valid && i_mem_write && !i_mem_io;
         DBG_AT_IO: type_ok = i_mem_valid && i_mem_io && i_de;
         DBG_AT_RDWR: type_ok = i_mem_valid && !i_mem_io;
      endcase
   end

   // execution compares the fetch address under the same length mask
   assign o_hit = (dbg_access_t'(i_rw) == DBG_AT_EXEC) ? (i_insn_valid && ((i_insn_ip & mask) == lo))
                  : (type_ok && overlap);
endmodule : dbg_bp_match
`default_nettype wire

/* File: dbg_defs.svh */
// constants for the breakpoint and debug control unit
`ifndef DBG_DEFS_SVH
`define DBG_DEFS_SVH

// model register indices
`define DBG_MSR_CTL 32'h0000_01d9
`define DBG_MSR_BR_SRC 32'h0000_01db
`define DBG_MSR_BR_DST 32'h0000_01dc
`define DBG_MSR_INT_SRC 32'h0000_01dd
`define DBG_MSR_INT_DST 32'h0000_01de

// debug control fields
`define DBG_CTL_REC 0
`define DBG_CTL_STEP 1
`define DBG_CTL_PIN_LO 2
`define DBG_CTL_MASK 64'h0000_0000_0000_003f
`define DBG_CTL_RESET 6'h00

// breakpoint control register layout
`define DBG_BC_RW_LO 16
`define DBG_BC_LEN_LO 18
`define DBG_BC_FIELD_STEP 4
`define DBG_BC_WMASK 32'hffff_23ff
`define DBG_BC_FIXED 32'h0000_0400
`define DBG_BC_LOCAL_MASK 32'h0000_0055
`define DBG_BC_GLOBAL_MASK 32'h0000_00aa
`define DBG_BC_IDX 4'h7

// exception vector
`define DBG_VECTOR 8'h01

`endif

/* File: dbg_pkg.sv */
// types for the breakpoint and debug control unit
package dbg_pkg;
   typedef enum logic [1:0] {
      DBG_AT_EXEC = 2'h0,
      DBG_AT_WRITE = 2'h1,
      DBG_AT_IO = 2'h2,
      DBG_AT_RDWR = 2'h3
   } dbg_access_t;

   typedef enum logic [1:0] {
      DBG_LEN_1 = 2'h0,
      DBG_LEN_2 = 2'h1,
      DBG_LEN_8 = 2'h2,
      DBG_LEN_4 = 2'h3
   } dbg_len_t;
endpackage : dbg_pkg

/* File: dbg_pm.sv */
// pipeline partner model: fetch, memory and i/o accesses, retire and transfers
`timescale 1ns/1ps
`default_nettype none
module dbg_pm (
   input wire logic i_clk,
   output logic o_iv,
   output logic [63:0] o_iip,
   output logic o_mv,
   output logic o_mw,
   output logic o_mio,
   output logic [63:0] o_ma,
   output logic [3:0] o_ms,
   output logic o_xv,
   output logic o_xi,
   output logic [63:0] o_xs,
   output logic [63:0] o_xd,
   output logic o_ret
);
   ////////////////////////////////////////////////////////////////////////
   // idle stage; released address lines carry inverted junk, not old values
   initial begin
      {o_iv, o_mv, o_mw, o_mio, o_xv, o_xi, o_ret} = 7'h00;
      {o_iip, o_ma, o_xs, o_xd} = {4{64'h5a5a_a5a5_0f0f_f0f0}};
      o_ms = 4'h1;
   end
   // one access held for exactly one sampling edge
   task automatic mem(input logic [63:0] a, input logic [3:0] s, input logic w, input logic io);
      @(posedge i_clk);
      o_mv <= 1'h1;
      o_mw <= w;
      o_mio <= io;
      o_ma <= a;
      o_ms <= s;
      @(posedge i_clk);
      o_mv <= 1'h0;
      o_ma <= ~a;
      #1;
   endtask : mem
   // instruction fetch address offered for execution compare
   task automatic fetch(input logic [63:0] ip);
      @(posedge i_clk);
      o_iv <= 1'h1;
      o_iip <= ip;
      @(posedge i_clk);
      o_iv <= 1'h0;
      o_iip <= ~ip;
      #1;
   endtask : fetch
   // retire, optionally with a taken transfer (v=0: plain retire)
   task automatic xfer(input logic v, input logic [63:0] s, input logic [63:0] d, input logic i);
      @(posedge i_clk);
      o_ret <= 1'h1;
      o_xv <= v;
      o_xi <= i;
      o_xs <= s;
      o_xd <= d;
      @(posedge i_clk);
      {o_ret, o_xv} <= 2'h0;
      o_xs <= ~s;
      o_xd <= ~d;
      #1;
   endtask : xfer
endmodule : dbg_pm
`default_nettype wire

/* File: dbg_unit.sv */
// breakpoint and debug control unit beside the execute and memory stages
`timescale 1ns/1ps
`default_nettype none
`include "dbg_defs.svh"
module dbg_unit
   import dbg_pkg::*;
#(
   parameter int NUM_BP = 4,
   parameter logic [7:0] EXT_IMPL = 8'h00
)
(
   input wire logic I_CLK,
   input wire logic I_RST_B,
   // model register instructions
   input wire logic I_MSR_RD,
   input wire logic I_MSR_WR,
   input wire logic [31:0] I_MSR_ADDR,
   input wire logic [63:0] I_MSR_WDATA,
   // debug register move instructions
   input wire logic I_DR_RD,
   input wire logic I_DR_WR,
   input wire logic [2:0] I_MODRM_REG,
   input wire logic I_REX_R,
   input wire logic I_MODE64,
   input wire logic [63:0] I_DR_WDATA,
   // pipeline state
   input wire logic I_DE,
   input wire logic I_TRAP_FLAG,
   input wire logic I_TASK_SWITCH,
   input wire logic I_RETIRE,
   input wire logic I_INSN_VALID,
   input wire logic [63:0] I_INSN_IP,
   input wire logic I_MEM_VALID,
   input wire logic I_MEM_WRITE,
   input wire logic I_MEM_IO,
   input wire logic [63:0] I_MEM_ADDR,
   input wire logic [3:0] I_MEM_SIZE,
   input wire logic I_XFER_VALID,
   input wire logic I_XFER_IS_INT,
   input wire logic [63:0] I_XFER_SRC,
   input wire logic [63:0] I_XFER_DST,
   input wire logic [NUM_BP-1:0] I_PERF_EVT,
   // answers
   output logic O_ACK,
   output logic [63:0] O_RDATA,
   output logic O_UD,
   output logic O_DBG_EXC,
   output logic [7:0] O_DBG_VECTOR,
   output logic [NUM_BP-1:0] O_BP_HIT,
   output logic [NUM_BP-1:0] O_EXT_PIN
);
   logic [63:0] bp_addr [NUM_BP];
   logic [63:0] next_bp_addr [NUM_BP];
   logic [31:0] bc;
   logic [31:0] next_bc;
   logic [5:0] ctl;
   logic [5:0] next_ctl;
   logic frozen;
   logic next_frozen;
   logic [3:0] dr_idx;
   logic dr_access;
   logic dr_impl;
   logic [NUM_BP-1:0] raw_hit;
   logic [NUM_BP-1:0] en_hit;
   logic step;
   logic fire;
   logic [63:0] br_src;
   logic [63:0] br_dst;
   logic [63:0] int_src;
   logic [63:0] int_dst;
   logic next_ack;
   logic [63:0] next_rdata;
   logic next_ud;
   logic dr_wr_ok;
   logic ctl_wr;

   ////////////////////////////////////////////////////////////////////////
   // debug register select

   // extension bit only counts in 64-bit mode
   assign dr_idx = {I_MODE64 & I_REX_R, I_MODRM_REG};
   assign dr_access = I_DR_RD || I_DR_WR;
   assign dr_impl = !dr_idx[3] || EXT_IMPL[dr_idx[2:0]];

   // decoded writes; extended indices never reach the low register file
   assign dr_wr_ok = I_DR_WR && dr_impl && !dr_idx[3];
   assign ctl_wr = I_MSR_WR && (I_MSR_ADDR == `DBG_MSR_CTL);

   ////////////////////////////////////////////////////////////////////////
   // breakpoint comparators

   genvar g;
   generate
      for (g = 0; g < NUM_BP; g++) begin : g_bp
         dbg_bp_match u_match (
            .i_base(bp_addr[g]),
            .i_rw(bc[`DBG_BC_RW_LO + g*`DBG_BC_FIELD_STEP +: 2]),
            .i_len(bc[`DBG_BC_LEN_LO + g*`DBG_BC_FIELD_STEP +: 2]),
            .i_de(I_DE),
            .i_insn_valid(I_INSN_VALID),
            .i_insn_ip(I_INSN_IP),
            .i_mem_valid(I_MEM_VALID),
            .i_mem_write(I_MEM_WRITE),
            .i_mem_io(I_MEM_IO),
            .i_mem_addr(I_MEM_ADDR),
            .i_mem_size(I_MEM_SIZE),
            .o_hit(raw_hit[g])
         );
         // either enable lets a match become an exception
         assign en_hit[g] = raw_hit[g] && (bc[2*g] || bc[2*g+1]);
      end
   endgenerate

   // single step: every retire, or only on transfers when the step bit is set
   assign step = I_TRAP_FLAG && I_RETIRE && (!ctl[`DBG_CTL_STEP] || I_XFER_VALID);
   assign fire = (|en_hit) || step;

   ////////////////////////////////////////////////////////////////////////
   // recording registers

   dbg_xfer_rec u_rec (
      .i_clk(I_CLK),
      .i_rst_b(I_RST_B),
      .i_enable(ctl[`DBG_CTL_REC] && !frozen),
      .i_xfer_valid(I_XFER_VALID),
      .i_xfer_is_int(I_XFER_IS_INT),
      .i_xfer_src(I_XFER_SRC),
      .i_xfer_dst(I_XFER_DST),
      .o_br_src(br_src),
      .o_br_dst(br_dst),
      .o_int_src(int_src),
      .o_int_dst(int_dst)
   );

   ////////////////////////////////////////////////////////////////////////
   // control state

   // writes first, then the hardware clear of per-task enables on top
   always_comb begin
      next_bp_addr = bp_addr;
      next_bc = bc;
      next_ctl = ctl;
      next_frozen = frozen;
      if (dr_wr_ok) begin
         if (dr_idx[2:0] < 3'(NUM_BP)) begin
            next_bp_addr[dr_idx[1:0]] = I_DR_WDATA;
         end else if (dr_idx == `DBG_BC_IDX) begin
            next_bc = (I_DR_WDATA[31:0] & `DBG_BC_WMASK) | `DBG_BC_FIXED;
         end
      end
      if (I_TASK_SWITCH) begin
         next_bc = next_bc & ~`DBG_BC_LOCAL_MASK;
      end
      // only the model register write reaches this register
      if (ctl_wr) begin
         next_ctl = I_MSR_WDATA[5:0];
         next_frozen = 1'b0;
      end
      // hold the record for the handler; the exception wins over a rewrite
      if (fire) begin
         next_frozen = 1'b1;
      end
   end

   // register stage
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         for (int i = 0; i < NUM_BP; i++) begin
            bp_addr[i] <= 64'h0;
         end
         bc <= `DBG_BC_FIXED;
         ctl <= `DBG_CTL_RESET;
         frozen <= 1'b0;
      end else begin
         bp_addr <= next_bp_addr;
         bc <= next_bc;
         ctl <= next_ctl;
         frozen <= next_frozen;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read answers and exception outputs

   // model register reads take priority over debug register reads
   always_comb begin
      next_ack = I_MSR_RD || I_MSR_WR || (dr_access && dr_impl);
      next_ud = dr_access && !dr_impl;
      next_rdata = 64'h0;
      if (I_MSR_RD) begin
         unique case (I_MSR_ADDR)
            `DBG_MSR_CTL: next_rdata = {58'h0, ctl} & `DBG_CTL_MASK;
            `DBG_MSR_BR_SRC: next_rdata = br_src;
            `DBG_MSR_BR_DST: next_rdata = br_dst;
            `DBG_MSR_INT_SRC: next_rdata = int_src;
            `DBG_MSR_INT_DST: next_rdata = int_dst;
            default: next_rdata = 64'h0;
         endcase
      end else if (I_DR_RD && dr_impl && !dr_idx[3]) begin
         if (dr_idx[2:0] < 3'(NUM_BP)) begin
            next_rdata = bp_addr[dr_idx[1:0]];
         end else if (dr_idx == `DBG_BC_IDX) begin
            next_rdata = {32'h0, bc};
         end
      end
   end

   // registered answers; pins pick breakpoint or monitor information
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_ACK <= 1'b0;
         O_RDATA <= 64'h0;
         O_UD <= 1'b0;
         O_DBG_EXC <= 1'b0;
         O_BP_HIT <= '0;
         O_EXT_PIN <= '0;
      end else begin
         O_ACK <= next_ack;
         O_RDATA <= next_rdata;
         O_UD <= next_ud;
         O_DBG_EXC <= fire;
         O_BP_HIT <= en_hit;
         for (int i = 0; i < NUM_BP; i++) begin
            O_EXT_PIN[i] <= ctl[`DBG_CTL_PIN_LO + i] ? raw_hit[i] : I_PERF_EVT[i];
         end
      end
   end

   assign O_DBG_VECTOR = `DBG_VECTOR;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);

   sequence rec_xfer_s;
      ctl[`DBG_CTL_REC] && !frozen && I_XFER_VALID && !I_XFER_IS_INT;
   endsequence

   sequence rec_loaded_s;
      br_src == $past(I_XFER_SRC) && br_dst == $past(I_XFER_DST);
   endsequence

   ext_select_a: assert property (I_DR_RD && I_MODE64 && I_REX_R && EXT_IMPL == 8'h00 |=> O_UD && !O_ACK)
      else $error("extended select did not trap");
   ud_raise_a: assert property (dr_access && dr_idx[3] && !EXT_IMPL[dr_idx[2:0]] |=> O_UD)
      else $error("unimplemented register access not trapped");
   rec_load_a: assert property (rec_xfer_s |=> rec_loaded_s)
      else $error("branch record not loaded");
   rec_hold_a: assert property (frozen && !(I_MSR_WR && I_MSR_ADDR == `DBG_MSR_CTL) |=> $stable(br_src) && frozen)
      else $error("record changed after exception");
   task_clear_a: assert property (I_TASK_SWITCH |=> (bc & `DBG_BC_LOCAL_MASK) == 32'h0)
      else $error("per-task enables survived task switch");
   global_keep_a: assert property (!I_DR_WR |=> (bc & `DBG_BC_GLOBAL_MASK) == ($past(bc) & `DBG_BC_GLOBAL_MASK))
      else $error("all-task enables changed by hardware");
   step_all_a: assert property (I_TRAP_FLAG && I_RETIRE && !ctl[`DBG_CTL_STEP] |=> O_DBG_EXC)
      else $error("normal single step missed");
   step_branch_a: assert property (I_TRAP_FLAG && I_RETIRE && ctl[`DBG_CTL_STEP] && !I_XFER_VALID && en_hit == '0
      |=> !O_DBG_EXC)
      else $error("branch step fired without transfer");
   hit_enable_a: assert property (O_BP_HIT != '0 |-> O_DBG_EXC && O_DBG_VECTOR == 8'h01)
      else $error("enabled hit without debug exception");
   ctl_rsvd_a: assert property (I_MSR_RD && I_MSR_ADDR == `DBG_MSR_CTL |=> O_RDATA[63:6] == 58'h0)
      else $error("reserved control bits read nonzero");
   pin_route_a: assert property (ctl[`DBG_CTL_PIN_LO] |=> O_EXT_PIN[0] == $past(raw_hit[0]))
      else $error("pin zero not reporting breakpoint");

   // interrupt pair loads like the branch pair, on its own flag
   sequence rec_int_s;
      ctl[`DBG_CTL_REC] && !frozen && I_XFER_VALID && I_XFER_IS_INT;
   endsequence

   sequence rec_int_loaded_s;
      int_src == $past(I_XFER_SRC) && int_dst == $past(I_XFER_DST);
   endsequence

   // recording, write paths and enable gating
   int_load_a: assert property (rec_int_s |=> rec_int_loaded_s)
      else $error("interrupt record not loaded");
   rec_off_a: assert property (!ctl[`DBG_CTL_REC] |=> $stable(br_src) && $stable(int_src))
      else $error("record moved while recording off");
   rec_ro_a: assert property (I_MSR_WR && I_MSR_ADDR == `DBG_MSR_BR_DST && !I_XFER_VALID |=> $stable(br_dst))
      else $error("record register took a software write");
   br_read_a: assert property (I_MSR_RD && I_MSR_ADDR == `DBG_MSR_BR_SRC |=> O_RDATA == $past(br_src))
      else $error("branch source read wrong");
   frozen_set_a: assert property (O_DBG_EXC |-> frozen)
      else $error("exception did not hold the record");
   io_gate_a: assert property (I_MEM_IO && !I_DE && !I_INSN_VALID |-> raw_hit == '0)
      else $error("io match without debug extensions");
   msr_ack_a: assert property (I_MSR_RD || I_MSR_WR |=> O_ACK)
      else $error("model register access not acknowledged");
   step_xfer_a: assert property (I_TRAP_FLAG && I_RETIRE && ctl[`DBG_CTL_STEP] && I_XFER_VALID |=> O_DBG_EXC)
      else $error("branch step missed on transfer");
   bp_write_a: assert property (I_DR_WR && dr_idx == 4'h0 |=> bp_addr[0] == $past(I_DR_WDATA))
      else $error("breakpoint address not written");
   ctl_write_a: assert property (ctl_wr |=> ctl == $past(I_MSR_WDATA[5:0]))
      else $error("debug control not written");
   ctl_read_a: assert property (I_MSR_RD && I_MSR_ADDR == `DBG_MSR_CTL |=> O_RDATA[5:0] == $past(ctl))
      else $error("debug control read wrong");
   bp_gate_a: assert property (raw_hit[0] && !bc[0] && !bc[1] |=> !O_BP_HIT[0])
      else $error("disabled match reported as hit");
   bp_fire_a: assert property (raw_hit[0] && (bc[0] || bc[1]) |=> O_BP_HIT[0] && O_DBG_EXC)
      else $error("enabled match did not fire");
endmodule : dbg_unit
`default_nettype wire

/* File: dbg_xfer_rec.sv */
// control-transfer recording registers, read-only to software
`timescale 1ns/1ps
`default_nettype none
module dbg_xfer_rec
   import dbg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_enable,
   input wire logic i_xfer_valid,
   input wire logic i_xfer_is_int,
   input wire logic [63:0] i_xfer_src,
   input wire logic [63:0] i_xfer_dst,
   output logic [63:0] o_br_src,
   output logic [63:0] o_br_dst,
   output logic [63:0] o_int_src,
   output logic [63:0] o_int_dst
);
   logic [63:0] next_br_src;
   logic [63:0] next_br_dst;
   logic [63:0] next_int_src;
   logic [63:0] next_int_dst;

   // no write path exists here, so software can only read these
   always_comb begin
      next_br_src = o_br_src;
      next_br_dst = o_br_dst;
      next_int_src = o_int_src;
      next_int_dst = o_int_dst;
      if (i_enable && i_xfer_valid) begin
         if (i_xfer_is_int) begin
            next_int_src = i_xfer_src;
            next_int_dst = i_xfer_dst;
         end else begin
            next_br_src = i_xfer_src;
            next_br_dst = i_xfer_dst;
         end
      end
   end

   // register stage
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_br_src <= 64'h0;
         o_br_dst <= 64'h0;
         o_int_src <= 64'h0;
         o_int_dst <= 64'h0;
      end else begin
         o_br_src <= next_br_src;
         o_br_dst <= next_br_dst;
         o_int_src <= next_int_src;
         o_int_dst <= next_int_dst;
      end
   end
endmodule : dbg_xfer_rec
`default_nettype wire

/* File: tb_dbg_unit.sv */
// self-checking bench for the breakpoint and debug control unit
`timescale 1ns/1ps
`default_nettype none
`include "dbg_defs.svh"
module tb_dbg_unit;
   logic clk = 1'h0, rst_b = 1'h0, msr_rd = 1'h0, msr_wr = 1'h0, dr_rd = 1'h0, dr_wr = 1'h0;
   logic register_extension_prefix = 1'h0, mode64 = 1'h1, de = 1'h0, tf = 1'h0, tsw = 1'h0;
   logic [31:0] msr_addr = 32'h0;
   logic [2:0] modrm = 3'h0;
   logic [63:0] msr_wdata = 64'h0, dr_wdata = 64'h0;
   logic [3:0] perf = 4'h0;
   logic iv, mv, mw, mio, xv, xi, ret, ack, ud, exc;
   logic [63:0] iip, ma, xs, xd, rdata;
   logic [3:0] ms, hit, pin;
   logic [7:0] vec;
   int error_cnt = 0, cmp_count = 0;
   logic [43:0] e;
   logic [15:0] t;
   // {len, base, addr, size, hit}: partial overlaps at every range size
   logic [43:0] tbl [21] = '{44'h0_f000_effb_8_1, 44'h0_f000_effe_2_0, 44'h0_f000_effe_4_1,
      44'h0_f000_f000_1_1, 44'h0_f000_f001_2_0, 44'h0_f000_f005_4_0, 44'h3_f004_effb_8_0,
      44'h3_f004_effe_2_0, 44'h3_f004_effe_4_0, 44'h3_f004_f000_1_0, 44'h3_f004_f001_2_0,
      44'h3_f004_f005_4_1, 44'h2_f000_effb_8_1, 44'h2_f000_effe_2_0, 44'h2_f000_effe_4_1,
      44'h2_f000_f000_1_1, 44'h2_f000_f001_2_1, 44'h2_f000_f005_4_1, 44'h1_f000_f001_2_1,
      44'h1_f000_f002_1_0, 44'h1_f000_effe_2_0};
   // {type, ext enable, kind 0 fetch 1 read 2 write 3 io, hit}
   logic [15:0] ty [10] = '{16'h0001, 16'h0010, 16'h1021, 16'h1010, 16'h3011, 16'h3021,
      16'h3030, 16'h2030, 16'h2131, 16'h2110};

   dbg_unit dbg_unit_i (.I_CLK(clk), .I_RST_B(rst_b), .I_MSR_RD(msr_rd), .I_MSR_WR(msr_wr),
      .I_MSR_ADDR(msr_addr), .I_MSR_WDATA(msr_wdata), .I_DR_RD(dr_rd), .I_DR_WR(dr_wr),
      .I_MODRM_REG(modrm), .I_REX_R(register_extension_prefix), .I_MODE64(mode64), .I_DR_WDATA(dr_wdata), .I_DE(de),
      .I_TRAP_FLAG(tf), .I_TASK_SWITCH(tsw), .I_RETIRE(ret), .I_INSN_VALID(iv), .I_INSN_IP(iip),
      .I_MEM_VALID(mv), .I_MEM_WRITE(mw), .I_MEM_IO(mio), .I_MEM_ADDR(ma), .I_MEM_SIZE(ms),
      .I_XFER_VALID(xv), .I_XFER_IS_INT(xi), .I_XFER_SRC(xs), .I_XFER_DST(xd), .I_PERF_EVT(perf),
      .O_ACK(ack), .O_RDATA(rdata), .O_UD(ud), .O_DBG_EXC(exc), .O_DBG_VECTOR(vec),
      .O_BP_HIT(hit), .O_EXT_PIN(pin));
   dbg_pm dbg_pm_i (.i_clk(clk), .o_iv(iv), .o_iip(iip), .o_mv(mv), .o_mw(mw), .o_mio(mio),
      .o_ma(ma), .o_ms(ms), .o_xv(xv), .o_xi(xi), .o_xs(xs), .o_xd(xd), .o_ret(ret));

   ////////////////////////////////////////////////////////////////////////
   // clock and watchdog; a hang counts as a mismatch
   always #10 clk = ~clk;
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////
   // compare tasks
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_exc(input logic x, input logic [3:0] h);
      cmp_count++;
      if ({exc, hit, vec} !== {x, h, 8'h01}) begin
         error_cnt++;
         $display("[ERR] %0t exception %b hits %b vector %h", $time, exc, hit, vec);
      end
   endtask : chk_exc
   // one request, sampled at the next edge; answer looked at just after it
   task automatic acc(input logic m, input logic w, input logic [31:0] a, input logic [63:0] d);
      @(posedge clk);
      if (m) begin
         {msr_rd, msr_wr} <= {~w, w};
         msr_addr <= a;
         msr_wdata <= d;
      end else begin
         {dr_rd, dr_wr} <= {~w, w};
         {register_extension_prefix, modrm} <= a[3:0];
         dr_wdata <= d;
      end
      @(posedge clk);
      {msr_rd, msr_wr, dr_rd, dr_wr} <= 4'h0;
      #1;
   endtask : acc
   task automatic rd(input logic m, input logic [31:0] a, input logic [63:0] x);
      acc(m, 1'h0, a, 64'h0);
      chk(64'(ack), 64'h1);
      chk(rdata, x);
   endtask : rd
   task automatic wr(input logic m, input logic [31:0] a, input logic [63:0] d);
      acc(m, 1'h1, a, d);
      chk(64'(ack), 64'h1);
   endtask : wr
   task automatic done(input string n);
      $display("test %s done, errors %0d", n, error_cnt);
   endtask : done
   task automatic stop_test();
      $display("comparisons %0d, errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'h1;
      rd(1'h1, `DBG_MSR_CTL, 64'h0);
      rd(1'h0, 32'h7, 64'h400);
      rd(1'h1, `DBG_MSR_BR_SRC, 64'h0);
      wr(1'h1, `DBG_MSR_CTL, 64'hffff_ffff_ffff_ffff);
      rd(1'h1, `DBG_MSR_CTL, 64'h3f);
      done("control");
      // extended debug register select only widens in 64-bit mode
      acc(1'h0, 1'h0, 32'hf, 64'h0);
      chk(64'({ud, ack}), 64'h2);
      acc(1'h0, 1'h1, 32'h8, 64'h0);
      chk(64'({ud, ack}), 64'h2);
      @(posedge clk);
      mode64 <= 1'h0;
      rd(1'h0, 32'hf, 64'h400);
      @(posedge clk);
      mode64 <= 1'h1;
      done("extended");
      // range table, read/write type, all-task enable of register 0
      for (int k = 0; k < 21; k++) begin
         e = tbl[k];
         wr(1'h0, 32'h0, {48'h0, e[39:24]});
         wr(1'h0, 32'h7, {44'h0, e[41:40], 10'h3_04, 8'h02});
         dbg_pm_i.mem({48'h0, e[23:8]}, e[7:4], 1'h0, 1'h0);
         chk_exc(e[0], {3'h0, e[0]});
      end
      rd(1'h0, 32'h0, 64'hf000);
      done("ranges");
      wr(1'h0, 32'h0, 64'h2000);
      for (int k = 0; k < 10; k++) begin
         t = ty[k];
         @(posedge clk);
         de <= t[8];
         wr(1'h0, 32'h7, {44'h0, 2'h0, t[13:12], 16'h04_02});
         if (t[5:4] == 2'h0)
            dbg_pm_i.fetch(64'h2000);
         else
            dbg_pm_i.mem(64'h2000, 4'h1, t[5:4] == 2'h2, t[5:4] == 2'h3);
         chk_exc(t[0], {3'h0, t[0]});
      end
      done("types");
      // no enable: no exception, pin 0 shows the raw match, others perf info
      wr(1'h1, `DBG_MSR_CTL, 64'h4);
      @(posedge clk);
      perf <= 4'ha;
      wr(1'h0, 32'h7, 64'h0003_0400);
      dbg_pm_i.mem(64'h2000, 4'h1, 1'h0, 1'h0);
      chk_exc(1'h0, 4'h0);
      chk(64'(pin), 64'hb);
      wr(1'h0, 32'h7, 64'h0003_0401);
      dbg_pm_i.mem(64'h2000, 4'h1, 1'h0, 1'h0);
      chk_exc(1'h1, 4'h1);
      done("enables");
      // task switch drops per-task enables only
      wr(1'h0, 32'h7, 64'h4ff);
      @(posedge clk);
      tsw <= 1'h1;
      @(posedge clk);
      tsw <= 1'h0;
      rd(1'h0, 32'h7, 64'h4aa);
      wr(1'h0, 32'h7, 64'h400);
      done("task switch");
      // single step on every retire, then on transfers only
      wr(1'h1, `DBG_MSR_CTL, 64'h0);
      @(posedge clk);
      tf <= 1'h1;
      dbg_pm_i.xfer(1'h0, 64'h10, 64'h20, 1'h0);
      chk_exc(1'h1, 4'h0);
      wr(1'h1, `DBG_MSR_CTL, 64'h2);
      dbg_pm_i.xfer(1'h0, 64'h10, 64'h20, 1'h0);
      chk_exc(1'h0, 4'h0);
      dbg_pm_i.xfer(1'h1, 64'h10, 64'h20, 1'h0);
      chk_exc(1'h1, 4'h0);
      @(posedge clk);
      tf <= 1'h0;
      done("step");
      // recording; the write also releases the hold left by the step exception
      wr(1'h1, `DBG_MSR_CTL, 64'h1);
      dbg_pm_i.xfer(1'h1, 64'h1111, 64'h2222, 1'h0);
      rd(1'h1, `DBG_MSR_BR_SRC, 64'h1111);
      rd(1'h1, `DBG_MSR_BR_DST, 64'h2222);
      dbg_pm_i.xfer(1'h1, 64'h3333, 64'h4444, 1'h1);
      rd(1'h1, `DBG_MSR_INT_SRC, 64'h3333);
      rd(1'h1, `DBG_MSR_INT_DST, 64'h4444);
      @(posedge clk);
      tf <= 1'h1;
      dbg_pm_i.xfer(1'h1, 64'h5555, 64'h6666, 1'h0);
      chk_exc(1'h1, 4'h0);
      @(posedge clk);
      tf <= 1'h0;
      dbg_pm_i.xfer(1'h1, 64'h7777, 64'h8888, 1'h0);
      rd(1'h1, `DBG_MSR_BR_SRC, 64'h5555);
      wr(1'h1, `DBG_MSR_BR_DST, 64'h0);
      rd(1'h1, `DBG_MSR_BR_DST, 64'h6666);
      done("recording");
      stop_test();
   end
endmodule : tb_dbg_unit
`default_nettype wire
